// >>> rtl/mb_pkg.sv
/*
 * Constants, frame layout and types for the single-register-write and
 * diagnostics-echo query handler.
 * Assumes byte framing (frame start/end) is done by a line layer outside.
 */
// Overview of operation
// - write target is register field plus 40001
// - write value field is exactly two bytes
// - address zero write accepted as broadcast
// - addressed write replies with identical frame
// - broadcast write performs write, sends nothing
// - writes only to holding register area
// - diagnostics supports only subfunction zero, echoes
// - diagnostics data returned unchanged
// - diagnostics with address zero is invalid
// - diagnostics reply reproduces whole query
package mb_pkg;
    localparam int FRAME_LEN = 8;
    localparam logic [7:0] FC_WRITE_SINGLE = 8'h06;
    localparam logic [7:0] FC_DIAG = 8'h08;
    localparam logic [7:0] BROADCAST_ADDR = 8'h00;
    localparam logic [15:0] DIAG_SUB_RETURN = 16'h0000;
    localparam logic [15:0] HOLD_REG_BASE = 16'h9c41; // 40001 decimal
    localparam logic [15:0] CRC_INIT = 16'hffff;
    localparam logic [15:0] CRC_POLY = 16'ha001;
    localparam logic [2:0] IDX_FC = 3'h1;
    localparam logic [2:0] IDX_ADR_HI = 3'h2;
    localparam logic [2:0] IDX_ADR_LO = 3'h3;
    localparam logic [2:0] IDX_VAL_HI = 3'h4;
    localparam logic [2:0] IDX_VAL_LO = 3'h5;
    localparam logic [2:0] IDX_CRC_LO = 3'h6;
    localparam logic [2:0] IDX_LAST = 3'h7;
    typedef enum logic [1:0] {ST_RX, ST_CHECK, ST_TX} state_t;
endpackage : mb_pkg

// >>> rtl/frame_if.sv
/*
 * Interface carrying the stored query frame from the buffer to the handler.
 * Assumes one writer (handler) and a registered read of one byte at a time, selected by rd_idx.
 */
`timescale 1ns/1ps
interface frame_if;
    logic wr_en;
    logic [2:0] wr_idx;
    logic [7:0] wr_data;
    logic [2:0] rd_idx;
    logic [7:0] rd_data;
    modport owner (output wr_en, output wr_idx, output wr_data, output rd_idx, input rd_data);
    modport store (input wr_en, input wr_idx, input wr_data, input rd_idx, output rd_data);
endinterface : frame_if

// >>> rtl/frame_mem.sv
/*
 * Eight-byte frame store; read data comes out of a register (one cycle).
 * Assumes the owner holds rd_idx for a cycle before using rd_data.
 */
`timescale 1ns/1ps
module frame_mem #(
    parameter int DEPTH = mb_pkg::FRAME_LEN
) (
    input wire logic clk, // system clock
    input wire logic rst, // async reset, active high
    frame_if.store fif // frame access
);
    logic [7:0] mem_reg [DEPTH];
    logic [7:0] rd_reg;
    logic [7:0] rd_next;

    // registered read path
    always_comb begin
        rd_next = mem_reg[fif.rd_idx];
    end

    always_ff @(posedge clk) begin
        if (fif.wr_en) begin
            mem_reg[fif.wr_idx] <= fif.wr_data;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rd_reg <= 8'h00;
        end else begin
            rd_reg <= rd_next;
        end
    end

    assign fif.rd_data = rd_reg;
endmodule : frame_mem

// >>> rtl/mb_handler.sv
/*
 * Query handler for single-register write and diagnostics return-query-data.
 * Receives a frame byte stream, checks crc and address, writes or echoes.
 * Assumes rx_start marks the first byte and rx_end follows the last byte;
 * frames of other length or function are ignored here.
 */
`timescale 1ns/1ps
module mb_handler #(
    parameter logic [7:0] OWN_ADDR = 8'h01 // this station's address
) (
    input wire logic clk, // system clock
    input wire logic rst, // async reset, active high
    input wire logic rx_valid, // received byte strobe
    input wire logic [7:0] rx_data, // received byte
    input wire logic rx_start, // with first byte of a frame
    input wire logic rx_end, // frame gap seen, one pulse
    output logic tx_valid, // transmit byte strobe
    output logic [7:0] tx_data, // transmit byte
    input wire logic tx_ready, // line takes tx byte
    output logic wr_valid, // holding register write pulse
    output logic [15:0] wr_number, // decimal register number
    output logic [15:0] wr_value, // value to write
    input wire logic wr_allowed, // number lies in writable area
    output logic busy // frame held for processing
);
    frame_if fif();
    frame_mem u_mem (.clk(clk), .rst(rst), .fif(fif));

    mb_pkg::state_t st_reg, st_next;
    logic [3:0] cnt_reg, cnt_next;
    logic [15:0] crc_reg, crc_next;
    logic [7:0] addr_reg, addr_next, fc_reg, fc_next;
    logic [15:0] f1_reg, f1_next, f2_reg, f2_next;
    logic [2:0] txi_reg, txi_next;
    logic primed_reg, primed_next;
    logic tx_valid_next, wr_valid_next, busy_next;
    logic [7:0] tx_data_next;
    logic [15:0] wr_number_next, wr_value_next;
    logic crc_ok, addr_ok, is_bcast, is_write, is_diag;

    // crc-16 over one byte, reflected polynomial
    function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
        logic [15:0] r;
        r = c ^ {8'h00, d};
        for (int i = 0; i < 8; i++) begin
            r = r[0] ? ((r >> 1) ^ mb_pkg::CRC_POLY) : (r >> 1);
        end
        return r;
    endfunction : crc_byte

    // a good frame leaves the running crc at zero, covering the crc bytes too
    assign crc_ok = (crc_reg == 16'h0000) && (cnt_reg == 4'(mb_pkg::FRAME_LEN));
    assign is_bcast = (addr_reg == mb_pkg::BROADCAST_ADDR);
    assign addr_ok = (addr_reg == OWN_ADDR) || is_bcast;
    assign is_write = (fc_reg == mb_pkg::FC_WRITE_SINGLE);
    assign is_diag = (fc_reg == mb_pkg::FC_DIAG) && (f1_reg == mb_pkg::DIAG_SUB_RETURN)
        && !is_bcast;

    // receive, decide, then echo the stored frame
    always_comb begin
        st_next = st_reg;
        cnt_next = cnt_reg;
        crc_next = crc_reg;
        addr_next = addr_reg;
        fc_next = fc_reg;
        f1_next = f1_reg;
        f2_next = f2_reg;
        txi_next = txi_reg;
        primed_next = 1'b0;
        tx_valid_next = tx_valid;
        tx_data_next = tx_data;
        wr_valid_next = 1'b0;
        wr_number_next = wr_number;
        wr_value_next = wr_value;
        busy_next = 1'b0;
        fif.wr_en = 1'b0;
        fif.wr_idx = cnt_reg[2:0];
        fif.wr_data = rx_data;
        fif.rd_idx = txi_reg;
        case (st_reg)
            mb_pkg::ST_RX: begin
                if (rx_valid) begin
                    if (rx_start) begin
                        cnt_next = 4'h1;
                        crc_next = crc_byte(mb_pkg::CRC_INIT, rx_data);
                        addr_next = rx_data;
                        fif.wr_idx = 3'h0;
                        fif.wr_en = 1'b1;
                    end else if (cnt_reg != 4'h0 && cnt_reg < 4'(mb_pkg::FRAME_LEN)) begin
                        cnt_next = cnt_reg + 4'h1;
                        crc_next = crc_byte(crc_reg, rx_data);
                        fif.wr_en = 1'b1;
                        // fields arrive high byte first
                        if (cnt_reg[2:0] == mb_pkg::IDX_FC) fc_next = rx_data;
                        if (cnt_reg[2:0] == mb_pkg::IDX_ADR_HI) f1_next = {rx_data, f1_reg[7:0]};
                        if (cnt_reg[2:0] == mb_pkg::IDX_ADR_LO) f1_next = {f1_reg[15:8], rx_data};
                        if (cnt_reg[2:0] == mb_pkg::IDX_VAL_HI) f2_next = {rx_data, f2_reg[7:0]};
                        if (cnt_reg[2:0] == mb_pkg::IDX_VAL_LO) f2_next = {f2_reg[15:8], rx_data};
                    end else begin
                        cnt_next = 4'h0; // overlong frame: never matches length check
                    end
                end
                if (rx_end) begin
                    st_next = mb_pkg::ST_CHECK;
                    busy_next = 1'b1;
                end
            end
            mb_pkg::ST_CHECK: begin
                st_next = mb_pkg::ST_RX;
                cnt_next = 4'h0;
                txi_next = 3'h0;
                if (crc_ok && addr_ok && is_write && wr_allowed) begin
                    wr_valid_next = 1'b1;
                    wr_value_next = f2_reg;
                    // number only moves with a write, so it holds until the next one
                    wr_number_next = 16'(f1_reg + mb_pkg::HOLD_REG_BASE);
                    if (!is_bcast) begin
                        st_next = mb_pkg::ST_TX;
                        busy_next = 1'b1;
                    end
                end else if (crc_ok && addr_ok && is_diag) begin
                    st_next = mb_pkg::ST_TX;
                    busy_next = 1'b1;
                end
            end
            default: begin
                // echo every stored byte unchanged, including the crc
                busy_next = 1'b1;
                if (!tx_valid && !primed_reg) begin
                    primed_next = 1'b1; // wait for registered read data
                end else if (!tx_valid) begin
                    tx_valid_next = 1'b1;
                    tx_data_next = fif.rd_data;
                end else if (tx_ready) begin
                    tx_valid_next = 1'b0;
                    if (txi_reg == mb_pkg::IDX_LAST) begin
                        st_next = mb_pkg::ST_RX;
                        busy_next = 1'b0;
                    end else begin
                        txi_next = txi_reg + 3'h1;
                    end
                end
            end
        endcase
    end

    // state registers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_reg <= mb_pkg::ST_RX;
            cnt_reg <= 4'h0;
            crc_reg <= mb_pkg::CRC_INIT;
            addr_reg <= 8'h00;
            fc_reg <= 8'h00;
            f1_reg <= 16'h0000;
            f2_reg <= 16'h0000;
            txi_reg <= 3'h0;
            primed_reg <= 1'b0;
            tx_valid <= 1'b0;
            tx_data <= 8'h00;
            wr_valid <= 1'b0;
            wr_number <= 16'h0000;
            wr_value <= 16'h0000;
            busy <= 1'b0;
        end else begin
            st_reg <= st_next;
            cnt_reg <= cnt_next;
            crc_reg <= crc_next;
            addr_reg <= addr_next;
            fc_reg <= fc_next;
            f1_reg <= f1_next;
            f2_reg <= f2_next;
            txi_reg <= txi_next;
            primed_reg <= primed_next;
            tx_valid <= tx_valid_next;
            tx_data <= tx_data_next;
            wr_valid <= wr_valid_next;
            wr_number <= wr_number_next;
            wr_value <= wr_value_next;
            busy <= busy_next;
        end
    end

    // checks
    sequence s_check_bcast;
        st_reg == mb_pkg::ST_CHECK && is_bcast;
    endsequence

    chk_write_number: assert property (@(posedge clk) disable iff (rst)
        wr_valid |-> wr_number == 16'($past(f1_reg) + mb_pkg::HOLD_REG_BASE))
        else $error("write number not field plus base");
    chk_bcast_silent: assert property (@(posedge clk) disable iff (rst)
        s_check_bcast |=> st_reg != mb_pkg::ST_TX)
        else $error("broadcast produced a reply");
    chk_bcast_write: assert property (@(posedge clk) disable iff (rst)
        s_check_bcast ##0 (crc_ok && is_write && wr_allowed) |=> wr_valid)
        else $error("broadcast write not performed");
    chk_bad_crc: assert property (@(posedge clk) disable iff (rst)
        (st_reg == mb_pkg::ST_CHECK && !crc_ok) |=> !wr_valid && st_reg == mb_pkg::ST_RX)
        else $error("bad frame acted upon");
    chk_foreign_addr: assert property (@(posedge clk) disable iff (rst)
        (st_reg == mb_pkg::ST_CHECK && !addr_ok) |=> !wr_valid)
        else $error("foreign address acted upon");
    chk_write_area: assert property (@(posedge clk) disable iff (rst)
        (st_reg == mb_pkg::ST_CHECK && !wr_allowed) |=> !wr_valid)
        else $error("write outside allowed area");
    chk_diag_bcast: assert property (@(posedge clk) disable iff (rst)
        (st_reg == mb_pkg::ST_CHECK && fc_reg == mb_pkg::FC_DIAG && is_bcast)
        |=> st_reg == mb_pkg::ST_RX)
        else $error("broadcast diagnostics answered");
    chk_diag_sub: assert property (@(posedge clk) disable iff (rst)
        (st_reg == mb_pkg::ST_CHECK && fc_reg == mb_pkg::FC_DIAG
        && f1_reg != mb_pkg::DIAG_SUB_RETURN) |=> st_reg == mb_pkg::ST_RX)
        else $error("unsupported subfunction answered");
    chk_write_reply: assert property (@(posedge clk) disable iff (rst)
        (st_reg == mb_pkg::ST_CHECK && crc_ok && addr_ok && !is_bcast && is_write && wr_allowed)
        |=> st_reg == mb_pkg::ST_TX ##2 tx_valid)
        else $error("addressed write not echoed");
    chk_write_value: assert property (@(posedge clk) disable iff (rst)
        wr_valid |-> wr_value == $past(f2_reg))
        else $error("write value not the two byte field");
endmodule : mb_handler

// >>> verif/mb_client.sv
/*
 * Behavioural serial client: sends whole query frames, takes reply bytes.
 * Assumes the line layer is abstracted to byte strobes and a gap pulse.
 */
`timescale 1ns/1ps
module mb_client (
    input wire logic clk, // system clock
    output logic rx_valid, // byte strobe to handler
    output logic [7:0] rx_data, // byte to handler
    output logic rx_start, // first byte marker
    output logic rx_end, // frame gap pulse
    input wire logic tx_valid, // reply byte offered
    input wire logic [7:0] tx_data, // reply byte
    output logic tx_ready // reply byte taken
);
    logic [7:0] got[$];
    int slow = 0;
    int cnt = 0;
    initial begin
        rx_valid = 1'b0;
        rx_data = 8'h00;
        rx_start = 1'b0;
        rx_end = 1'b0;
        tx_ready = 1'b0;
    end
    // whole frame, high field bytes first, crc low first
    task send(input logic [63:0] f);
        for (int i = 0; i < 8; i++) begin
            @(posedge clk);
            #1;
            rx_valid = 1'b1;
            rx_start = (i == 0);
            rx_data = f[63-8*i -: 8];
        end
        @(posedge clk);
        #1;
        rx_valid = 1'b0;
        rx_start = 1'b0;
        rx_data = ~rx_data; // stale byte never looks valid
        rx_end = 1'b1;
        @(posedge clk);
        #1;
        rx_end = 1'b0;
    endtask : send
    // collect replies; slow mode takes one byte in three cycles
    always @(posedge clk) begin
        if (tx_valid && tx_ready) got.push_back(tx_data);
        cnt++;
        #1 tx_ready = (slow == 0) || (cnt % 3 == 0);
    end
endmodule : mb_client

// >>> verif/tb_top.sv
/*
 * Self-checking bench for the query handler: table of frames, then reset.
 * Assumes the client model in mb_client.sv and station address 8'h05.
 */
`timescale 1ns/1ps
module tb_top;
    typedef struct packed {
        logic [47:0] body;
        logic bad, allowed, slow, wr, rep;
    } row_t;
    logic clk, rst, rx_valid, rx_start, rx_end, tx_valid, tx_ready;
    logic wr_valid, wr_allowed, busy;
    logic [7:0] rx_data, tx_data;
    logic [15:0] wr_number, wr_value, last_num, last_val;
    int errors = 0;
    int samples_checked = 0;
    int wr_cnt = 0;
    row_t rows[9];
    mb_handler #(.OWN_ADDR(8'h05)) i_dut (.clk(clk), .rst(rst), .rx_valid(rx_valid),
        .rx_data(rx_data), .rx_start(rx_start), .rx_end(rx_end), .tx_valid(tx_valid),
        .tx_data(tx_data), .tx_ready(tx_ready), .wr_valid(wr_valid), .wr_number(wr_number),
        .wr_value(wr_value), .wr_allowed(wr_allowed), .busy(busy));
    mb_client i_cl (.clk(clk), .rx_valid(rx_valid), .rx_data(rx_data), .rx_start(rx_start),
        .rx_end(rx_end), .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready));
    // clock at 50 MHz
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // log every write pulse
    always @(posedge clk) begin
        if (wr_valid === 1'b1) begin
            wr_cnt++;
            last_num = wr_number;
            last_val = wr_value;
        end
    end
    function automatic logic [15:0] crc16(input logic [47:0] b);
        logic [15:0] c;
        c = mb_pkg::CRC_INIT;
        for (int i = 0; i < 6; i++) begin
            c = c ^ {8'h00, b[47-8*i -: 8]};
            for (int j = 0; j < 8; j++) c = c[0] ? (c >> 1) ^ mb_pkg::CRC_POLY : c >> 1;
        end
        return c;
    endfunction : crc16
    task check(input logic [63:0] seen, input logic [63:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task stop_test;
        $display("errors=%0d samples_checked=%0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : stop_test
    // one frame end to end; wait for busy to fall under a bound
    task run(input row_t r);
        logic [63:0] f, g;
        logic [15:0] c;
        int w0, k;
        c = crc16(r.body) ^ {15'h0000, r.bad};
        f = {r.body, c[7:0], c[15:8]};
        w0 = wr_cnt;
        i_cl.got.delete();
        i_cl.slow = r.slow;
        wr_allowed = r.allowed;
        i_cl.send(f);
        k = 0;
        while (busy !== 1'b0 && k < 300) begin
            @(posedge clk);
            k++;
        end
        repeat (3) @(posedge clk); // processing gap after any query
        #1;
        check(busy, 1'b0);
        check(wr_cnt - w0, r.wr);
        if (r.wr) check(last_num, r.body[31:16] + mb_pkg::HOLD_REG_BASE);
        if (r.wr) check(last_val, r.body[15:0]);
        check(i_cl.got.size(), r.rep ? 8 : 0);
        g = '0;
        foreach (i_cl.got[i]) g = {g[55:0], i_cl.got[i]};
        if (r.rep) check(g, f);
    endtask : run
    // watchdog against a hung handshake
    initial begin
        #200000;
        errors++;
        stop_test();
    end
    // main sequence
    initial begin
        rst = 1'b1;
        wr_allowed = 1'b0;
        rows[0] = {48'h0506_000d_1770, 5'b01011};
        rows[1] = {48'h0006_0001_abcd, 5'b01010};
        rows[2] = {48'h0506_0010_1234, 5'b00000};
        rows[3] = {48'h0508_0000_ffff, 5'b00101};
        rows[4] = {48'h0508_0000_0000, 5'b00001};
        rows[5] = {48'h0508_0001_1234, 5'b00000};
        rows[6] = {48'h0008_0000_1234, 5'b00000};
        rows[7] = {48'h0706_000d_1770, 5'b01000};
        rows[8] = {48'h0506_0002_5555, 5'b11000};
        repeat (20) @(posedge clk);
        #1 rst = 1'b0;
        foreach (rows[i]) run(rows[i]);
        // reset in mid-frame clears outputs, then a clean write still works
        fork
            i_cl.send({48'h0506_000d_1770, 16'h1799});
            begin
                repeat (4) @(posedge clk);
                #1 rst = 1'b1;
                @(posedge clk);
                #1 check({tx_valid, wr_valid, busy}, 3'b000);
            end
        join
        @(posedge clk);
        #1 rst = 1'b0;
        run(rows[0]);
        run(rows[1]);
        run(rows[3]);
        stop_test();
    end
endmodule : tb_top
